/* hw/exec_monitor_pkg.sv */
/*
  Shared constants and carriers for the emulator execution monitor.
  Assumes a single machine-cycle clock domain shared with the host controller.
*/
package exec_monitor_pkg;
  localparam int unsigned AddrWidth     = 12;
  localparam int unsigned CountWidth    = 32;
  localparam logic [11:0] SmallLastAddr = 12'h7df;
  localparam logic [11:0] LargeLastAddr = 12'hfdf;
  localparam logic [31:0] CountMax      = 32'hffffffff;
  localparam logic [31:0] CountReset    = 32'h00000000;
  localparam logic [11:0] AddrReset     = 12'h000;

  // One fetch/execute report from the emulated core
  typedef struct packed {
    logic        valid;    // Instruction first byte executed this cycle
    logic [11:0] addr;
    logic        cycle;    // Machine cycle strobe
    logic        hold;     // Core in hold mode
  } core_event_t;

  // One host command, valid for a single cycle
  typedef struct packed {
    logic        setWindow;
    logic        useDefaults;
    logic [11:0] startAddr;
    logic [11:0] stopAddr;
    logic        cancelWindow;
    logic        preload;
    logic        negate;
    logic [31:0] preloadValue;
    logic        clearBits;
    logic        goWithStart;
    logic [11:0] readAddr;
  } host_cmd_t;
endpackage

/* hw/emulator_execution_monitor.sv */
/*
  Execution monitor: gated 32-bit cycle counter and per-address coverage bitmap.
  Assumes core events and host commands are synchronous to clock; the host only
  reads results while emulation is halted.
*/
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Cancel disables start/stop gating but keeps both saved addresses for later re-arm.
// - The host may load the counter with any value from zero to the 32-bit maximum.
// - A negated preload loads the all-ones maximum minus the supplied value.
// - Launching with an explicit start address clears the whole bitmap first.
// - Addresses span 0 to 7DF hex in small mode and 0 to FDF hex in large mode.
// - A host clear request zeros every coverage bit in the active range.
// - The counter is a 32-bit up-counter advancing once per machine cycle while enabled.
// - Counting starts passing a start-marked address and ends passing a stop-marked one.
// - No counting in hold mode nor for the stop-marked instruction.
// - Counter overflow past the maximum raises a break request.
module emulator_execution_monitor #(
  parameter int unsigned Depth = 4096
) (
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic                       largeMode,
  input  wire exec_monitor_pkg::core_event_t coreEvt,
  input  wire exec_monitor_pkg::host_cmd_t   hostCmd,
  output logic [31:0]                     cycleTotal,
  output logic                            coverageBit,
  output logic                            counting,
  output logic                            windowArmed,
  output logic                            overflowBreak
);
  import exec_monitor_pkg::*;

  logic [11:0] startAddr_q, startAddr_d, stopAddr_q, stopAddr_d;
  logic        armed_q, armed_d, counting_q, counting_d, brk_q, brk_d;
  logic [31:0] count_q, count_d;
  logic        covRd_q, covRd_d;
  logic [Depth-1:0] cov_q;
  logic [11:0] lastAddr;
  logic        inRange, hitStart, hitStop;

  // Active address span depends on device mode
  assign lastAddr = largeMode ? LargeLastAddr : SmallLastAddr;
  assign inRange  = coreEvt.addr <= lastAddr;
  assign hitStart = armed_q && coreEvt.valid && inRange && coreEvt.addr == startAddr_q;
  assign hitStop  = armed_q && coreEvt.valid && inRange && coreEvt.addr == stopAddr_q;

  // Window and counter next state; host preload wins over counting
  always_comb begin
    startAddr_d = startAddr_q;
    stopAddr_d  = stopAddr_q;
    armed_d     = armed_q;
    counting_d  = counting_q;
    count_d     = count_q;
    brk_d       = 1'b0;
    if (hostCmd.setWindow) begin
      if (!hostCmd.useDefaults) begin
        startAddr_d = hostCmd.startAddr;
        stopAddr_d  = hostCmd.stopAddr;
      end
      armed_d = 1'b1;
    end else if (hostCmd.cancelWindow) begin
      armed_d    = 1'b0;
      counting_d = 1'b0;
    end
    if (hitStop) begin
      counting_d = 1'b0;
    end else if (hitStart) begin
      counting_d = 1'b1;
    end
    if (hostCmd.preload) begin
      count_d = hostCmd.negate ? CountMax - hostCmd.preloadValue
                               : hostCmd.preloadValue;
    end else if (coreEvt.cycle && !coreEvt.hold && (counting_q || hitStart) && !hitStop) begin
      // Stop instruction itself is not counted
      count_d = count_q + 32'h00000001;
      brk_d   = count_q == CountMax;
    end
  end

  // Registers for window and counter
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      startAddr_q <= AddrReset;
      stopAddr_q  <= AddrReset;
      armed_q     <= 1'b0;
      counting_q  <= 1'b0;
      count_q     <= CountReset;
      brk_q       <= 1'b0;
    end else begin
      startAddr_q <= startAddr_d;
      stopAddr_q  <= stopAddr_d;
      armed_q     <= armed_d;
      counting_q  <= counting_d;
      count_q     <= count_d;
      brk_q       <= brk_d;
    end
  end

  // Coverage bitmap; a clear and an execute in one cycle: clear first, set wins
  for (genvar i = 0; i < Depth; i++) begin : g_cov
    logic covBit_d;
    always_comb begin
      covBit_d = cov_q[i];
      if (hostCmd.clearBits || hostCmd.goWithStart) begin
        covBit_d = 1'b0;
      end
      if (coreEvt.valid && inRange && coreEvt.addr == 12'(i)) begin
        covBit_d = 1'b1;
      end
    end
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        cov_q[i] <= 1'b0;
      end else begin
        cov_q[i] <= covBit_d;
      end
    end
  end

  // Host read port; out-of-range address reads zero
  always_comb begin
    covRd_d = (hostCmd.readAddr <= lastAddr) ? cov_q[hostCmd.readAddr] : 1'b0;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      covRd_q <= 1'b0;
    end else begin
      covRd_q <= covRd_d;
    end
  end

  assign cycleTotal    = count_q;
  assign coverageBit   = covRd_q;
  assign counting      = counting_q;
  assign windowArmed   = armed_q;
  assign overflowBreak = brk_q;

  property p_cancel_keeps;
    @(posedge clock) disable iff (rst)
      hostCmd.cancelWindow && !hostCmd.setWindow |=> !armed_q && $stable(startAddr_q) && $stable(stopAddr_q);
  endproperty
  a_cancel_keeps: assert property (p_cancel_keeps) else $error("cancel lost window");

  property p_preload;
    @(posedge clock) disable iff (rst)
      hostCmd.preload && !hostCmd.negate |=> count_q == $past(hostCmd.preloadValue);
  endproperty
  a_preload: assert property (p_preload) else $error("preload wrong");

  property p_neg_preload;
    @(posedge clock) disable iff (rst)
      hostCmd.preload && hostCmd.negate |=> count_q == ~$past(hostCmd.preloadValue);
  endproperty
  a_neg_preload: assert property (p_neg_preload) else $error("negated preload wrong");

  property p_cov_set;
    @(posedge clock) disable iff (rst)
      coreEvt.valid && coreEvt.addr <= lastAddr |=> cov_q[$past(coreEvt.addr)];
  endproperty
  a_cov_set: assert property (p_cov_set) else $error("coverage bit not set");

  property p_cov_clear;
    @(posedge clock) disable iff (rst)
      (hostCmd.clearBits || hostCmd.goWithStart) && !coreEvt.valid |=> cov_q == '0;
  endproperty
  a_cov_clear: assert property (p_cov_clear) else $error("bitmap not cleared");

  property p_hold;
    @(posedge clock) disable iff (rst)
      coreEvt.hold && !hostCmd.preload |=> $stable(count_q);
  endproperty
  a_hold: assert property (p_hold) else $error("counted in hold");

  property p_count;
    @(posedge clock) disable iff (rst)
      counting_q && coreEvt.cycle && !coreEvt.hold && !hitStop && !hostCmd.preload
      |=> count_q == $past(count_q) + 32'h00000001;
  endproperty
  a_count: assert property (p_count) else $error("counter missed cycle");

  property p_stop;
    @(posedge clock) disable iff (rst)
      hitStop |=> !counting_q;
  endproperty
  a_stop: assert property (p_stop) else $error("stop ignored");

  property p_ovf;
    @(posedge clock) disable iff (rst)
      overflowBreak |-> count_q == CountReset;
  endproperty
  a_ovf: assert property (p_ovf) else $error("false overflow");

  // Re-arm with defaults must reuse the saved range, not reset it
  property p_arm;
    @(posedge clock) disable iff (rst)
      hostCmd.setWindow && hostCmd.useDefaults |=> armed_q && $stable(startAddr_q) && $stable(stopAddr_q);
  endproperty
  a_arm: assert property (p_arm) else $error("defaults lost window");

  // A start mark alone always opens the window
  property p_start;
    @(posedge clock) disable iff (rst)
      hitStart && !hitStop |=> counting_q;
  endproperty
  a_start: assert property (p_start) else $error("start ignored");

  // The stop-marked instruction itself adds nothing
  property p_stop_nocount;
    @(posedge clock) disable iff (rst)
      hitStop && !hostCmd.preload |=> $stable(count_q);
  endproperty
  a_stop_nocount: assert property (p_stop_nocount) else $error("stop cycle counted");

  // Wrap from the maximum must raise the break pulse
  property p_ovf_set;
    @(posedge clock) disable iff (rst)
      counting_q && coreEvt.cycle && !coreEvt.hold && !hitStop && !hostCmd.preload && count_q == CountMax
      |=> overflowBreak;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow missed");

  // Execution beyond the active span leaves the bitmap alone
  property p_range;
    @(posedge clock) disable iff (rst)
      coreEvt.valid && !inRange && !hostCmd.clearBits && !hostCmd.goWithStart
      |=> cov_q == $past(cov_q);
  endproperty
  a_range: assert property (p_range) else $error("out of range bit set");

  // Reads beyond the active span return zero
  property p_read_range;
    @(posedge clock) disable iff (rst)
      hostCmd.readAddr > lastAddr |=> !coverageBit;
  endproperty
  a_read_range: assert property (p_read_range) else $error("out of range read nonzero");
endmodule // emulator_execution_monitor
`default_nettype wire

/* sim/core_model.sv */
/*
  Emulated core model: reports executed addresses, machine cycles and hold.
  Assumes the bench requests each report one clock ahead.
*/
`timescale 1ns/10ps
`default_nettype none
module core_model (
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire logic                        exec,
  input  wire logic [11:0]                 pc,
  input  wire logic                        run,
  input  wire logic                        holdIn,
  output var  exec_monitor_pkg::core_event_t evt
);
  import exec_monitor_pkg::*;

  // Idle address shows the inverse of the last one, so stale values never match
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      evt <= '0;
    end else begin
      evt.valid <= exec;
      evt.addr  <= exec ? pc : ~evt.addr;
      evt.cycle <= run;
      evt.hold  <= holdIn;
    end
  end
endmodule // core_model
`default_nettype wire

/* sim/testbench.sv */
/*
  Self-checking bench for the execution monitor.
  Assumes the core model adds one clock between request and report.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  import exec_monitor_pkg::*;
  logic        clock = 1'b0, rst = 1'b1, largeMode = 1'b0, exec = 1'b0, run = 1'b1, holdIn = 1'b0;
  logic [11:0] pc = 12'h000;
  host_cmd_t   hostCmd = '0;
  core_event_t coreEvt;
  logic [31:0] cycleTotal;
  logic        coverageBit, counting, windowArmed, overflowBreak;
  int          mismatches = 0, nTests = 0;
  core_model u_core (.clock(clock), .rst(rst), .exec(exec), .pc(pc), .run(run), .holdIn(holdIn), .evt(coreEvt));
  emulator_execution_monitor u_dut (.clock(clock), .rst(rst), .largeMode(largeMode), .coreEvt(coreEvt),
    .hostCmd(hostCmd), .cycleTotal(cycleTotal), .coverageBit(coverageBit), .counting(counting),
    .windowArmed(windowArmed), .overflowBreak(overflowBreak));
  // Clock and a watchdog far beyond the expected run of under 150 cycles
  initial forever #4 clock = ~clock;
  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    final_report();
  end
  task automatic cmd(input host_cmd_t h);
    @(posedge clock);
    hostCmd <= h;
    @(posedge clock);
    hostCmd <= '0;
  endtask
  task automatic step(input logic e, input logic [11:0] a, input logic h);
    @(posedge clock);
    exec <= e;
    pc <= a;
    holdIn <= h;
  endtask
  // Idle reports, then let the pipeline drain before sampling
  task automatic idle(input int n);
    repeat (n) step(1'b0, 12'h000, 1'b0);
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic rd(input logic [11:0] a, input logic exp);
    @(posedge clock);
    hostCmd.readAddr <= a;
    repeat (2) @(posedge clock);
    #1;
    `CHK(coverageBit, exp)
  endtask
  // Start, 3 plain, 2 held, 2 plain, stop: six counted cycles
  task automatic burst(input logic [31:0] base, input logic on);
    step(1'b1, 12'h010, 1'b0);
    repeat (3) step(1'b0, 12'h000, 1'b0);
    #1;
    `CHK(counting, on)
    repeat (2) step(1'b0, 12'h000, 1'b1);
    repeat (2) step(1'b0, 12'h000, 1'b0);
    step(1'b1, 12'h020, 1'b0);
    idle(2);
    `CHK(cycleTotal, on ? base + 32'h6 : base)
    `CHK(counting, 1'b0)
  endtask
  task automatic t_window;
    cmd('{setWindow: 1'b1, startAddr: 12'h010, stopAddr: 12'h020, default: '0});
    idle(0);
    `CHK(windowArmed, 1'b1)
    burst(32'h0, 1'b1);
    cmd('{cancelWindow: 1'b1, default: '0});
    idle(0);
    `CHK(windowArmed, 1'b0)
    burst(32'h6, 1'b0);
    cmd('{setWindow: 1'b1, useDefaults: 1'b1, default: '0});
    burst(32'h6, 1'b1);
    // Strobe low two cycles mid-window: only the start and the last plain cycle count
    step(1'b1, 12'h010, 1'b0);
    step(1'b0, 12'h000, 1'b0);
    run <= 1'b0;
    repeat (2) step(1'b0, 12'h000, 1'b0);
    run <= 1'b1;
    step(1'b1, 12'h020, 1'b0);
    idle(2);
    `CHK(cycleTotal, 32'hc + 32'h2)
    $display("done: window");
  endtask
  task automatic t_preload;
    int i;
    cmd('{preload: 1'b1, preloadValue: CountMax, default: '0});
    idle(0);
    `CHK(cycleTotal, CountMax)
    step(1'b1, 12'h010, 1'b0);
    for (i = 0; i < 8 && overflowBreak !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    `CHK(overflowBreak, 1'b1)
    step(1'b1, 12'h020, 1'b0);
    cmd('{preload: 1'b1, negate: 1'b1, preloadValue: 32'h1, default: '0});
    idle(0);
    `CHK(cycleTotal, CountMax - 32'h1)
    $display("done: preload");
  endtask
  task automatic t_coverage;
    int i;
    cmd('{goWithStart: 1'b1, default: '0});
    for (i = 0; i < 4; i++) step(1'b1, 12'h032 + 12'(i), 1'b0);
    step(1'b1, 12'h7e0, 1'b0);
    idle(1);
    rd(12'h033, 1'b1);
    rd(12'h036, 1'b0);
    rd(12'h7e0, 1'b0);
    @(posedge clock);
    largeMode <= 1'b1;
    rd(12'h7e0, 1'b0);
    step(1'b1, 12'h7e0, 1'b0);
    idle(1);
    rd(12'h7e0, 1'b1);
    cmd('{clearBits: 1'b1, default: '0});
    rd(12'h7e0, 1'b0);
    rd(12'h033, 1'b0);
    step(1'b1, 12'h040, 1'b0);
    idle(1);
    cmd('{goWithStart: 1'b1, default: '0});
    rd(12'h040, 1'b0);
    $display("done: coverage");
  endtask
  task automatic final_report;
    $display("tests=%0d mismatches=%0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    idle(0);
    `CHK(cycleTotal, CountReset)
    t_window();
    t_preload();
    t_coverage();
    final_report();
  end
endmodule // testbench
`default_nettype wire
